// ### pkg/crs_pkg.sv
package crs_pkg;

  // register index map on the plain register port
  localparam logic [3:0] IDX_ACC  = 4'h0;
  localparam logic [3:0] IDX_BASE = 4'h1;
  localparam logic [3:0] IDX_CNT  = 4'h2;
  localparam logic [3:0] IDX_DATA = 4'h3;
  localparam logic [3:0] IDX_SP   = 4'h4;
  localparam logic [3:0] IDX_BP   = 4'h5;
  localparam logic [3:0] IDX_PSEG = 4'h6;
  localparam logic [3:0] IDX_SSEG = 4'h7;
  localparam logic [3:0] IDX_DS0  = 4'h8;
  localparam logic [3:0] IDX_DS1  = 4'h9;
  localparam logic [3:0] IDX_PC   = 4'hA;
  localparam logic [3:0] IDX_PSW  = 4'hB;

  // number of writable word registers, first four split into bytes
  localparam int NUM_RW  = 10;
  localparam int NUM_GPR = 4;

  // status word bit positions
  localparam int BIT_CY  = 0;
  localparam int BIT_P   = 2;
  localparam int BIT_AC  = 4;
  localparam int BIT_Z   = 6;
  localparam int BIT_S   = 7;
  localparam int BIT_BRK = 8;
  localparam int BIT_IE  = 9;
  localparam int BIT_DIR = 10;
  localparam int BIT_V   = 11;
  localparam int BIT_MD  = 15;

  // fixed ones, storable bits below the mode flag, reset value
  localparam logic [15:0] PSW_ONES  = 16'h7002;
  localparam logic [15:0] PSW_LIVE  = 16'h0FD5;
  localparam logic [15:0] PSW_RST   = 16'h7002;
  localparam logic [15:0] REG_RST   = 16'h0000;
  localparam logic [15:0] RD_NONE   = 16'h0000;

  // write width select for the execution write port
  localparam logic [1:0] HALF_WORD = 2'h0;
  localparam logic [1:0] HALF_LOW  = 2'h1;
  localparam logic [1:0] HALF_HIGH = 2'h2;

  // flag update class of the finished operation
  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_ADDSUB = 3'h1,
    OP_INCDEC = 3'h2,
    OP_LOGIC  = 3'h3,
    OP_MUL    = 3'h4,
    OP_SHIFT  = 3'h5
  } crs_op_t;

  // direct carry commands
  typedef enum logic [1:0] {
    CY_KEEP = 2'h0,
    CY_SET  = 2'h1,
    CY_CLR  = 2'h2,
    CY_CMC  = 2'h3
  } crs_cycmd_t;

endpackage

// ### src/crs_register_set.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// Function
// - four word registers, independent byte halves
// - fixed default registers exported to datapath
// - four segment base registers held
// - stack pointer and frame base pointer
// - program counter increments per code byte
// - branch loads prefetch pointer
// - status word bit layout fixed
// - carry set, cleared, complemented directly
// - interrupt start clears gate and trap
// - reset clears flags except emulation flag
// - byte status access touches bits 7-0
// - whole status word saved and restored
// - add/sub carry from bit 7 or 15
// - increment/decrement keep carry
// - logical operations clear carry
// - multiply carry from upper word check
// - shift through carry loads shifted bit
// - parity even over low eight bits
// - zero flag over byte or word result
module crs_register_set
(
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic [3:0]          regAddr,
  input  wire logic [15:0]         regWrData,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [15:0]         regRdData,
  input  wire logic                exWrEn,
  input  wire logic [3:0]          exWrSel,
  input  wire logic [1:0]          exWrHalf,
  input  wire logic [15:0]         exWrData,
  input  wire crs_pkg::crs_op_t    exAluOp,
  input  wire logic                exByteOp,
  input  wire logic [15:0]         exResult,
  input  wire logic                exCarryOut,
  input  wire logic [15:0]         exMulHigh,
  input  wire logic                exMulSigned,
  input  wire logic                exMulImm8,
  input  wire logic                exShiftBit,
  input  wire crs_pkg::crs_cycmd_t exCyCmd,
  input  wire logic                exFetchByte,
  input  wire logic                exBranch,
  input  wire logic [15:0]         exPrefetchPtr,
  input  wire logic                exIrqStart,
  input  wire logic                exPswLoad,
  input  wire logic [15:0]         exPswData,
  input  wire logic                exPswLowLoad,
  input  wire logic                exPswToAh,
  output logic      [15:0]         accWord,
  output logic      [15:0]         countWord,
  output logic      [15:0]         dataWord,
  output logic      [15:0]         stackPtr,
  output logic      [15:0]         framePtr,
  output logic      [15:0]         progSegment,
  output logic      [15:0]         stackSegment,
  output logic      [15:0]         srcSegment,
  output logic      [15:0]         dstSegment,
  output logic      [15:0]         progCounter,
  output logic      [15:0]         statusWord
);
  import crs_pkg::*;

  logic [15:0] regs_q [NUM_RW];     // word registers and segment bases
  logic [15:0] pc_q;                // program counter
  logic [15:0] psw_q;               // stored status word, mode bit unused
  logic [15:0] psw_d;               // next status word
  logic        md_q;                // emulation mode flag, reset-free
  logic [15:0] rdData_q;            // read data, one cycle after strobe
  logic [15:0] pswView;             // status word as software sees it
  logic        busPsw;              // bus write to status word
  logic        wordLoad;            // any whole-word status restore
  logic [15:0] wordSrc;             // source of a whole-word restore
  logic        resZero;             // result zero at operation width
  logic        mulCy;               // multiply carry

  // status word view: mode flag, stored flags, constant bits
  assign pswView = {md_q, psw_q[14:0]};

  // whole-word status restore, execution pop/return first
  assign busPsw   = regWr && (regAddr == IDX_PSW);
  assign wordLoad = exPswLoad || busPsw;
  assign wordSrc  = exPswLoad ? exPswData : regWrData;

  // per-register write logic, bytes only on the first four
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RW; gi++)
    begin : g_reg
      logic exHit;   // execution port targets this entry
      logic busHit;  // register port targets this entry
      assign exHit  = exWrEn && (exWrSel == 4'(gi));
      assign busHit = regWr && (regAddr == 4'(gi));
      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
        begin
          regs_q[gi] <= REG_RST;
        end
        else if (exHit && gi < NUM_GPR && exWrHalf == HALF_LOW)
        begin
          regs_q[gi][7:0] <= exWrData[7:0];
        end
        else if (exHit && gi < NUM_GPR && exWrHalf == HALF_HIGH)
        begin
          regs_q[gi][15:8] <= exWrData[7:0];
        end
        else if (exHit)
        begin
          regs_q[gi] <= exWrData;
        end
        else if (gi == IDX_ACC && exPswToAh)
        begin
          regs_q[gi][15:8] <= pswView[7:0];
        end
        else if (busHit)
        begin
          regs_q[gi] <= regWrData;
        end
      end
    end
  endgenerate

  // program counter: branch load beats fetch increment
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_q <= REG_RST;
    end
    else if (exBranch)
    begin
      pc_q <= exPrefetchPtr;
    end
    else if (exFetchByte)
    begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  // zero test and multiply carry for the finished operation
  always_comb
  begin
    resZero = exByteOp ? (exResult[7:0] == 8'h00)
                       : (exResult == 16'h0000);
    if (exMulSigned || exMulImm8)
    begin
      mulCy = (exMulHigh != {16{exResult[15]}});
    end
    else
    begin
      mulCy = (exMulHigh != 16'h0000);
    end
  end

  // next status word: restore, flag update, carry command, irq
  always_comb
  begin
    psw_d = psw_q;
    if (wordLoad)
    begin
      psw_d = wordSrc;
    end
    else if (exPswLowLoad)
    begin
      psw_d[7:0] = regs_q[IDX_ACC][15:8];
    end
    unique case (exAluOp)
      OP_ADDSUB:
      begin
        psw_d[BIT_CY] = exCarryOut;
      end
      OP_LOGIC:
      begin
        psw_d[BIT_CY] = 1'b0;
      end
      OP_MUL:
      begin
        psw_d[BIT_CY] = mulCy;
      end
      OP_SHIFT:
      begin
        psw_d[BIT_CY] = exShiftBit;
      end
      default:
      begin
        psw_d[BIT_CY] = psw_d[BIT_CY];
      end
    endcase
    // parity, zero, sign after add/sub, inc/dec, logic, shift
    if (exAluOp != OP_NONE && exAluOp != OP_MUL)
    begin
      psw_d[BIT_P] = ~^exResult[7:0];
      psw_d[BIT_Z] = resZero;
      psw_d[BIT_S] = exByteOp ? exResult[7] : exResult[15];
    end
    // direct carry commands
    unique case (exCyCmd)
      CY_SET:  psw_d[BIT_CY] = 1'b1;
      CY_CLR:  psw_d[BIT_CY] = 1'b0;
      CY_CMC:  psw_d[BIT_CY] = ~psw_q[BIT_CY];
      CY_KEEP: psw_d[BIT_CY] = psw_d[BIT_CY];
    endcase
    // interrupt entry drops the gate and trap last
    if (exIrqStart)
    begin
      psw_d[BIT_IE]  = 1'b0;
      psw_d[BIT_BRK] = 1'b0;
    end
    psw_d = (psw_d & PSW_LIVE) | PSW_ONES;
  end

  // status flags, cleared by reset
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      psw_q <= PSW_RST;
    end
    else
    begin
      psw_q <= psw_d;
    end
  end

  // emulation flag, untouched by reset, only word restores
  always_ff @(posedge clk_sys)
  begin
    if (wordLoad)
    begin
      md_q <= wordSrc[BIT_MD];
    end
  end

  // register port read, data only in the cycle after strobe
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdData_q <= RD_NONE;
    end
    else if (regRd && regAddr < IDX_PC)
    begin
      rdData_q <= regs_q[regAddr];
    end
    else if (regRd && regAddr == IDX_PC)
    begin
      rdData_q <= pc_q;
    end
    else if (regRd && regAddr == IDX_PSW)
    begin
      rdData_q <= pswView;
    end
    else
    begin
      rdData_q <= RD_NONE;
    end
  end

  // outputs straight from the register flops
  assign regRdData    = rdData_q;
  assign accWord      = regs_q[IDX_ACC];
  assign countWord    = regs_q[IDX_CNT];
  assign dataWord     = regs_q[IDX_DATA];
  assign stackPtr     = regs_q[IDX_SP];
  assign framePtr     = regs_q[IDX_BP];
  assign progSegment  = regs_q[IDX_PSEG];
  assign stackSegment = regs_q[IDX_SSEG];
  assign srcSegment   = regs_q[IDX_DS0];
  assign dstSegment   = regs_q[IDX_DS1];
  assign progCounter  = pc_q;
  assign statusWord   = pswView;

  // checks on the design's own outputs
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_pc_inc;
    exFetchByte && !exBranch |=> pc_q == $past(pc_q) + 16'h0001;
  endproperty
  a_pc_inc: assert property (p_pc_inc)
    else $error("program counter did not step by one");

  property p_pc_branch;
    exBranch |=> pc_q == $past(exPrefetchPtr);
  endproperty
  a_pc_branch: assert property (p_pc_branch)
    else $error("program counter missed prefetch pointer");

  property p_irq_clr;
    exIrqStart |=> !statusWord[BIT_IE] && !statusWord[BIT_BRK];
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("interrupt entry left gate or trap set");

  property p_logic_cy;
    exAluOp == OP_LOGIC && exCyCmd == CY_KEEP |=> !statusWord[BIT_CY];
  endproperty
  a_logic_cy: assert property (p_logic_cy)
    else $error("logical operation left carry set");

  property p_incdec_cy;
    exAluOp == OP_INCDEC && exCyCmd == CY_KEEP && !wordLoad
      && !exPswLowLoad |=> statusWord[BIT_CY] == $past(statusWord[BIT_CY]);
  endproperty
  a_incdec_cy: assert property (p_incdec_cy)
    else $error("increment or decrement changed carry");

  property p_fixed;
    statusWord[14:12] == 3'h7 && !statusWord[5] && !statusWord[3]
      && statusWord[1];
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed status bits moved");

  property p_parity;
    exAluOp == OP_ADDSUB |=> statusWord[BIT_P] == ~^$past(exResult[7:0]);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity flag wrong after add or subtract");

  property p_zero;
    exAluOp == OP_LOGIC && exByteOp
      |=> statusWord[BIT_Z] == ($past(exResult[7:0]) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong after byte operation");

  // set, one quiet cycle, then complement must leave carry clear
  property p_cy_set;
    exCyCmd == CY_SET
      ##1 exCyCmd == CY_KEEP && exAluOp == OP_NONE && !wordLoad && !exPswLowLoad
      ##1 exCyCmd == CY_CMC && exAluOp == OP_NONE
      |=> !statusWord[BIT_CY];
  endproperty
  a_cy_set: assert property (p_cy_set)
    else $error("carry set then complement did not clear");

  property p_byte_wr;
    exWrEn && exWrSel == IDX_ACC && exWrHalf == HALF_LOW
      |=> accWord[15:8] == $past(accWord[15:8]);
  endproperty
  a_byte_wr: assert property (p_byte_wr)
    else $error("low byte write disturbed high byte");

  property p_low_load;
    exPswLowLoad && !wordLoad && !exIrqStart
      |=> statusWord[15:8] == $past(statusWord[15:8]);
  endproperty
  a_low_load: assert property (p_low_load)
    else $error("byte status restore touched upper bits");

  // add or subtract takes the datapath carry out
  property p_add_cy;
    exAluOp == OP_ADDSUB && exCyCmd == CY_KEEP
      |=> statusWord[BIT_CY] == $past(exCarryOut);
  endproperty
  a_add_cy: assert property (p_add_cy)
    else $error("carry did not follow add or subtract");

  // shift through carry loads the shifted bit
  property p_shift_cy;
    exAluOp == OP_SHIFT && exCyCmd == CY_KEEP
      |=> statusWord[BIT_CY] == $past(exShiftBit);
  endproperty
  a_shift_cy: assert property (p_shift_cy)
    else $error("carry did not take the shifted bit");

  // no fetch and no branch keeps the program counter
  property p_pc_hold;
    !exFetchByte && !exBranch |=> $stable(pc_q);
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("program counter moved without fetch or branch");

  c_fetch_branch: cover property (exFetchByte ##1 exBranch);
  c_irq: cover property (exIrqStart && statusWord[BIT_IE]);
  c_mul_cy: cover property (exAluOp == OP_MUL && mulCy);
  c_cy_cmc: cover property (exCyCmd == CY_SET ##2 exCyCmd == CY_CMC);

endmodule

// ### verification/crs_exec_model.sv
`timescale 1ns/10ps
// datapath stand-in: one finished operation per request
module crs_exec_model
(
  input  wire logic             clk_sys,
  input  wire logic             opGo,
  input  wire crs_pkg::crs_op_t opKind,
  input  wire logic             opByte,
  input  wire logic             opSigned,
  input  wire logic [15:0]      opA,
  input  wire logic [15:0]      opB,
  output crs_pkg::crs_op_t      exAluOp,
  output logic                  exByteOp,
  output logic      [15:0]      exResult,
  output logic                  exCarryOut,
  output logic      [15:0]      exMulHigh,
  output logic                  exMulSigned,
  output logic                  exMulImm8,
  output logic                  exShiftBit
);
  import crs_pkg::*;
  logic        [16:0] sum;   // adder with carry out
  logic        [31:0] prodU; // unsigned product
  logic signed [31:0] prodS; // signed product
  // arithmetic of the request
  always_comb
  begin
    sum   = {1'h0, opA} + {1'h0, opB};
    prodU = opA * opB;
    prodS = $signed(opA) * $signed(opB);
  end
  // registered result; idle data wanders instead of holding
  always_ff @(posedge clk_sys)
  begin
    exAluOp     <= opGo ? opKind : OP_NONE;
    exByteOp    <= opByte;
    exMulSigned <= opSigned;
    exMulImm8   <= 1'h0;
    exShiftBit  <= opByte ? opA[7] : opA[15];
    exCarryOut  <= 1'h1;       // stray carry the block must ignore
    exMulHigh   <= ~exMulHigh;
    exResult    <= ~exResult;
    if (opGo)
    begin
      case (opKind)
        OP_ADDSUB:
        begin
          exResult   <= sum[15:0];
          exCarryOut <= opByte ? sum[8] : sum[16];
        end
        OP_INCDEC: exResult <= opA + 16'h0001;
        OP_LOGIC:  exResult <= opA & opB;
        OP_SHIFT:  exResult <= opA << 1;
        OP_MUL:
        begin
          exResult  <= opSigned ? prodS[15:0] : prodU[15:0];
          exMulHigh <= opSigned ? prodS[31:16] : prodU[31:16];
        end
        default:   exResult <= opA;
      endcase
    end
  end
endmodule

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  import crs_pkg::*;
  // operation row: kind, byte, signed, operands, expected status low byte
  typedef struct packed
  {crs_op_t k; logic b; logic s; logic [15:0] x; logic [15:0] y; logic [7:0] e;} crs_row_t;
  logic        clk_sys, rst_b, regWr, regRd, exWrEn, exFetchByte, exBranch;
  logic        exIrqStart, exPswLoad, exPswLowLoad, exPswToAh, opGo, opByte, opSigned;
  logic        exByteOp, exCarryOut, exMulSigned, exMulImm8, exShiftBit;
  logic [3:0]  regAddr, exWrSel;
  logic [1:0]  exWrHalf;
  logic [15:0] regWrData, regRdData, exWrData, exResult, exMulHigh, exPrefetchPtr;
  logic [15:0] exPswData, opA, opB, accWord, countWord, dataWord, stackPtr, framePtr;
  logic [15:0] progSegment, stackSegment, srcSegment, dstSegment, progCounter, statusWord;
  crs_op_t     exAluOp, opKind;
  crs_cycmd_t  exCyCmd;
  int          nErrors, nCompared;
  crs_row_t    rows [0:9] = '{
    '{OP_ADDSUB, 1'h0, 1'h0, 16'hFFFF, 16'h0001, 8'h47}, '{OP_LOGIC, 1'h0, 1'h0, 16'h00FF, 16'h0F0F, 8'h06},
    '{OP_ADDSUB, 1'h1, 1'h0, 16'h007F, 16'h0001, 8'h82}, '{OP_ADDSUB, 1'h0, 1'h0, 16'hFFFF, 16'h0001, 8'h47},
    '{OP_INCDEC, 1'h0, 1'h0, 16'h7FFF, 16'h0000, 8'h87}, '{OP_SHIFT, 1'h0, 1'h0, 16'h8001, 16'h0000, 8'h03},
    '{OP_SHIFT, 1'h1, 1'h0, 16'h0040, 16'h0000, 8'h82}, '{OP_MUL, 1'h0, 1'h0, 16'h0100, 16'h0100, 8'h83},
    '{OP_MUL, 1'h0, 1'h1, 16'hFFFF, 16'h0002, 8'h82}, '{OP_LOGIC, 1'h1, 1'h0, 16'h0000, 16'h00FF, 8'h46}};
  crs_cycmd_t  cmds [0:3] = '{CY_SET, CY_CMC, CY_CMC, CY_CLR};
  crs_register_set i_crs_register_set (.*);
  crs_exec_model i_crs_exec_model (.*);
  // free-running clock
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and stop
  task automatic endSim();
    if (nErrors == 0 && nCompared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // taking edge: drop every pulse, then let outputs settle
  task automatic take();
    @(posedge clk_sys);
    {regWr, regRd, exWrEn, exFetchByte, exBranch, exIrqStart} <= 6'h00;
    {exPswLoad, exPswLowLoad, exPswToAh, opGo} <= 4'h0;
    exCyCmd <= CY_KEEP;
    #1;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    take();
    @(posedge clk_sys);
  endtask
  task automatic bus_rd(input logic [3:0] a, input logic [15:0] e);
    regAddr <= a;
    regRd <= 1'h1;
    take();
    check(regRdData, e);
    @(posedge clk_sys);
  endtask
  task automatic exw(input logic [3:0] s, input logic [1:0] h, input logic [15:0] d);
    {exWrSel, exWrHalf, exWrData} <= {s, h, d};
    exWrEn <= 1'h1;
    take();
  endtask
  // hang guard
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    nErrors++;
    endSim();
  end
  // main sequence
  initial
  begin
    {rst_b, regWr, regRd, exWrEn, exFetchByte, exBranch, exIrqStart} = 7'h00;
    {exPswLoad, exPswLowLoad, exPswToAh, opGo, opByte, opSigned} = 6'h00;
    {regAddr, exWrSel, exWrHalf} = 10'h000;
    {regWrData, exWrData, exPrefetchPtr, exPswData, opA, opB} = 96'h0;
    {opKind, exCyCmd, nErrors, nCompared} = '0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    check({1'h0, statusWord[14:0]}, 16'h7002);
    for (int i = 0; i < 11; i++) bus_rd(4'(i), 16'h0000);
    foreach (rows[i])
    begin
      {opKind, opByte, opSigned, opA, opB} <= {rows[i].k, rows[i].b, rows[i].s, rows[i].x, rows[i].y};
      opGo <= 1'h1;
      take();
      @(posedge clk_sys);
      #1 check({1'h0, statusWord[14:0]}, {8'h70, rows[i].e});
      @(posedge clk_sys);
    end
    for (int i = 0; i < 10; i++)
    begin
      bus_wr(4'(i), 16'hA500 | 16'(i));
      bus_rd(4'(i), 16'hA500 | 16'(i));
    end
    check(countWord, 16'hA502);
    check(dataWord, 16'hA503);
    check(stackPtr ^ framePtr, 16'h0001);
    check(progSegment + stackSegment + srcSegment + dstSegment, 16'h941E);
    exw(IDX_ACC, HALF_LOW, 16'h00CD);
    check(accWord, 16'hA5CD);
    @(posedge clk_sys);
    exw(IDX_ACC, HALF_HIGH, 16'h0012);
    check(accWord, 16'h12CD);
    bus_wr(IDX_PC, 16'hFFFF);
    bus_rd(IDX_PC, 16'h0000);
    bus_rd(4'hC, 16'h0000);
    exFetchByte <= 1'h1;
    repeat (2) @(posedge clk_sys);
    take();
    check(progCounter, 16'h0003);
    @(posedge clk_sys);
    {exBranch, exFetchByte, exPrefetchPtr} <= {2'h3, 16'h1234};
    take();
    check(progCounter, 16'h1234);
    foreach (cmds[j])
    begin
      @(posedge clk_sys);
      exCyCmd <= cmds[j];
      take();
      check({15'h0, statusWord[BIT_CY]}, 16'(~j & 1));
    end
    @(posedge clk_sys);
    {exPswLoad, exPswData} <= {1'h1, 16'hFFFF};
    take();
    check(statusWord, 16'hFFD7);
    @(posedge clk_sys);
    exIrqStart <= 1'h1;
    take();
    check(statusWord, 16'hFCD7);
    @(posedge clk_sys);
    exPswToAh <= 1'h1;
    take();
    check(accWord, 16'hD7CD);
    @(posedge clk_sys);
    exw(IDX_ACC, HALF_HIGH, 16'h0000);
    @(posedge clk_sys);
    exPswLowLoad <= 1'h1;
    take();
    check(statusWord, 16'hFC02);
    @(posedge clk_sys);
    bus_wr(IDX_PSW, 16'h0000);
    bus_rd(IDX_PSW, 16'h7002);
    {exPswLoad, exPswData} <= {1'h1, 16'h8000};
    take();
    @(posedge clk_sys);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'h1;
    take();
    check(statusWord, 16'hF002);
    check(accWord, 16'h0000);
    endSim();
  end
endmodule
